// ===== common/bpm_pkg.sv
// Shared constants, types and helpers of the receive parity error monitor
package bpm_pkg;

  localparam int BPM_AW = 16;
  localparam int BPM_DW = 32;
  localparam int BPM_NLINE = 3;

  // Register indices; byte address is four times the index
  localparam logic [15:0] BPM_IDX_CTRL = 16'h1103;
  localparam logic [15:0] BPM_IDX_STAT = 16'h110B;
  localparam logic [15:0] BPM_IDX_MASK = 16'h110F;
  localparam logic [15:0] BPM_IDX_SCNT = 16'h1110;
  localparam logic [15:0] BPM_IDX_LCNT = 16'h1114;
  localparam logic [15:0] BPM_ADDR_CTRL = {BPM_IDX_CTRL[13:0], 2'b00};
  localparam logic [15:0] BPM_ADDR_STAT = {BPM_IDX_STAT[13:0], 2'b00};
  localparam logic [15:0] BPM_ADDR_MASK = {BPM_IDX_MASK[13:0], 2'b00};
  localparam logic [15:0] BPM_ADDR_SCNT = {BPM_IDX_SCNT[13:0], 2'b00};
  localparam logic [15:0] BPM_ADDR_LCNT = {BPM_IDX_LCNT[13:0], 2'b00};

  // Field positions
  localparam int BPM_CTRL_B1_FRAME = 0;
  localparam int BPM_CTRL_B2_FRAME = 1;
  localparam int BPM_STAT_B1_ERR = 3;
  localparam int BPM_STAT_B2_ERR = 4;
  localparam logic [7:0] BPM_CTRL_RW_MASK = 8'h7F;
  localparam logic [7:0] BPM_STAT_IMPL_MASK = 8'h18;

  // Reset values
  localparam logic [7:0] BPM_CTRL_RST = 8'h00;
  localparam logic [7:0] BPM_STAT_RST = 8'h00;
  localparam logic [7:0] BPM_MASK_RST = 8'h18;
  localparam logic [31:0] BPM_CNT_RST = 32'h0000_0000;

  localparam logic [1:0] BPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] BPM_RESP_DECERR = 2'h3;

  // One byte from the upstream framer with its position tags
  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic soh;
    logic b1;
    logic b2;
    logic [1:0] sts_idx;
  } bpm_rx_byte_t;

  function automatic logic [3:0] bpm_popcount8(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction

endpackage

// ===== hdl/bpm_bip_acc.sv
// Interleaved parity accumulator holding the result of the last complete frame
`timescale 1ns/1ps
module bpm_bip_acc #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_start,
  input wire logic take,
  input wire logic [W-1:0] din,
  output logic [W-1:0] parity_last,
  output logic parity_ok
);

  logic [W-1:0] acc_q;
  logic seen_q;

  // Accumulate; frame start closes the old frame and opens a new one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_q <= '0;
      parity_last <= '0;
    end
    else if (frame_start)
    begin
      parity_last <= acc_q;
      acc_q <= take ? din : '0;
    end
    else if (take)
    begin
      acc_q <= acc_q ^ din;
    end
  end

  // First frame start closes a partial frame, so its parity is not trusted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seen_q <= 1'b0;
      parity_ok <= 1'b0;
    end
    else if (frame_start)
    begin
      seen_q <= 1'b1;
      parity_ok <= seen_q;
    end
  end

endmodule // bpm_bip_acc

// ===== hdl/bpm_monitor.sv
// Receive section and line parity monitor with error counters and AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - B1 bit mode adds errored bits, max 8
// - Compute line parity over LOH and envelope
// - Compare line parity with next frame B2
// - B2 mismatch sets status bit 4, interrupt low
// - B2 errors advance 32-bit line counter
// - B2 frame mode adds one per errored frame
// - B2 bit mode adds errored bits, max 24
// - B1 frame mode adds one per errored frame
// - Section parity over frame, compare next B1
// - B1 mismatch sets status bit 3, interrupt low
// - B1 errors kept in separate section counter
module bpm_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire bpm_pkg::bpm_rx_byte_t rx_byte,
  input wire logic [bpm_pkg::BPM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [bpm_pkg::BPM_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bpm_pkg::BPM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [bpm_pkg::BPM_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_n
);
  import bpm_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [31:0] sec_cnt_q;
  logic [31:0] line_cnt_q;
  logic b2_hit_q;

  logic [BPM_AW-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic wr_fire;
  logic rd_fire;
  logic stat_rd;

  logic frame_start;
  logic [7:0] sec_par;
  logic sec_ok;
  logic [7:0] line_par [BPM_NLINE];
  logic line_ok [BPM_NLINE];
  logic [7:0] b1_err_bits;
  logic [7:0] b2_err_bits;
  logic b1_evt;
  logic b2_evt;
  logic [31:0] sec_add;
  logic [31:0] line_add;

  assign frame_start = rx_valid && rx_byte.sof;

  // Section parity runs over every byte of the frame
  bpm_bip_acc #(
    .W(8)
  ) u_sec_bip (
    .aclk(aclk),
    .aresetn(aresetn),
    .frame_start(frame_start),
    .take(rx_valid),
    .din(rx_byte.data),
    .parity_last(sec_par),
    .parity_ok(sec_ok)
  );

  // One line parity per interleaved tributary, section overhead rows excluded
  for (genvar k = 0; k < BPM_NLINE; k++)
  begin : g_line
    logic take_k;
    assign take_k = rx_valid && !rx_byte.soh && (rx_byte.sts_idx == 2'(k));
    bpm_bip_acc #(
      .W(8)
    ) u_line_bip (
      .aclk(aclk),
      .aresetn(aresetn),
      .frame_start(frame_start),
      .take(take_k),
      .din(rx_byte.data),
      .parity_last(line_par[k]),
      .parity_ok(line_ok[k])
    );
  end

  // Held parity of the previous frame against the arriving parity bytes
  always_comb
  begin
    b1_err_bits = 8'h00;
    b2_err_bits = 8'h00;
    if (rx_valid && rx_byte.b1 && sec_ok)
    begin
      b1_err_bits = sec_par ^ rx_byte.data;
    end
    if (rx_valid && rx_byte.b2 && (rx_byte.sts_idx < 2'(BPM_NLINE)))
    begin
      if (line_ok[rx_byte.sts_idx])
      begin
        b2_err_bits = line_par[rx_byte.sts_idx] ^ rx_byte.data;
      end
    end
  end

  assign b1_evt = |b1_err_bits;
  assign b2_evt = |b2_err_bits;

  // Counter increments per mode
  always_comb
  begin
    sec_add = 32'h0000_0000;
    line_add = 32'h0000_0000;
    if (ctrl_q[BPM_CTRL_B1_FRAME])
    begin
      sec_add = {31'h0000_0000, b1_evt};
    end
    else
    begin
      sec_add = {28'h000_0000, bpm_popcount8(b1_err_bits)};
    end
    if (ctrl_q[BPM_CTRL_B2_FRAME])
    begin
      line_add = {31'h0000_0000, b2_evt && !b2_hit_q};
    end
    else
    begin
      line_add = {28'h000_0000, bpm_popcount8(b2_err_bits)};
    end
  end

  // Marks a frame already counted in per-frame line mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      b2_hit_q <= 1'b0;
    end
    else if (frame_start)
    begin
      b2_hit_q <= 1'b0;
    end
    else if (b2_evt)
    begin
      b2_hit_q <= 1'b1;
    end
  end

  // Counters wrap; software takes differences between reads
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_cnt_q <= BPM_CNT_RST;
      line_cnt_q <= BPM_CNT_RST;
    end
    else
    begin
      sec_cnt_q <= sec_cnt_q + sec_add;
      line_cnt_q <= line_cnt_q + line_add;
    end
  end

  // Sticky status; a new event in the clearing cycle survives the read
  always_comb
  begin
    stat_d = stat_rd ? BPM_STAT_RST : stat_q;
    stat_d[BPM_STAT_B1_ERR] = stat_d[BPM_STAT_B1_ERR] | b1_evt;
    stat_d[BPM_STAT_B2_ERR] = stat_d[BPM_STAT_B2_ERR] | b2_evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= BPM_STAT_RST;
      irq_n <= 1'b1;
    end
    else
    begin
      stat_q <= stat_d;
      irq_n <= ~|(stat_d & mask_q);
    end
  end

  // Write channel: address and data taken in either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BPM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        waddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_q)
          BPM_ADDR_CTRL, BPM_ADDR_STAT, BPM_ADDR_MASK, BPM_ADDR_SCNT, BPM_ADDR_LCNT:
            s_axi_bresp <= BPM_RESP_OKAY;
          default:
            s_axi_bresp <= BPM_RESP_DECERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers; status and counters ignore writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= BPM_CTRL_RST;
      mask_q <= BPM_MASK_RST;
    end
    else if (wr_fire && wstrb_q[0])
    begin
      if (waddr_q == BPM_ADDR_CTRL)
      begin
        ctrl_q <= wdata_q[7:0] & BPM_CTRL_RW_MASK;
      end
      if (waddr_q == BPM_ADDR_MASK)
      begin
        mask_q <= wdata_q[7:0] & BPM_STAT_IMPL_MASK;
      end
    end
  end

  // Read channel: one read outstanding
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_fire && (s_axi_araddr == BPM_ADDR_STAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BPM_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= BPM_RESP_OKAY;
      case (s_axi_araddr)
        BPM_ADDR_CTRL:
          s_axi_rdata <= {24'h00_0000, ctrl_q};
        BPM_ADDR_STAT:
          s_axi_rdata <= {24'h00_0000, stat_q};
        BPM_ADDR_MASK:
          s_axi_rdata <= {24'h00_0000, mask_q};
        BPM_ADDR_SCNT:
          s_axi_rdata <= sec_cnt_q;
        BPM_ADDR_LCNT:
          s_axi_rdata <= line_cnt_q;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= BPM_RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // bpm_monitor

// ===== verification/bpm_monitor_asserts.sv
// Port level checks of the receive parity monitor
`timescale 1ns/1ps
module bpm_monitor_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire bpm_pkg::bpm_rx_byte_t rx_byte,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [bpm_pkg::BPM_DW-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_n
);
  import bpm_pkg::*;
  logic ev;
  assign ev = rx_valid && (rx_byte.b1 || rx_byte.b2);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_IRQ_CAUSE: assert property ($fell(irq_n) |-> $past(ev) || $past(ev, 2))
    else $error("irq low without check byte");
  AST_IRQ_RELEASE: assert property ($rose(irq_n) |-> s_axi_rvalid || $past(s_axi_rvalid) || $past(s_axi_bvalid))
    else $error("irq released without access");
  AST_B_REFUSE: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during response");
  cover property (!irq_n);
  cover property (ev);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // bpm_monitor_asserts

bind bpm_monitor bpm_monitor_asserts u_chk (.*);

// ===== verification/bpm_framer_model.sv
// Upstream framer model sending tagged frames
`timescale 1ns/1ps
module bpm_framer_model (
  input wire logic aclk,
  output logic rx_valid,
  output bpm_pkg::bpm_rx_byte_t rx_byte
);
  import bpm_pkg::*;
  logic [7:0] sp_q;
  logic [23:0] lp_q;
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = '0;
    sp_q = 8'h00;
    lp_q = 24'h0;
  end
  // Errors flip bits of the check bytes
  task automatic send(input logic [7:0] e1, input logic [23:0] e2);
    bpm_rx_byte_t b;
    logic [7:0] s;
    logic [23:0] l;
    s = 8'h00;
    l = 24'h0;
    for (int i = 0; i < 12; i++)
    begin
      b = '0;
      b.data = 8'($urandom);
      b.sof = (i == 0);
      b.soh = (i < 2);
      b.b1 = (i == 1);
      b.b2 = (i inside {[2:4]});
      b.sts_idx = b.soh ? 2'h3 : 2'((i + 1) % 3);
      if (b.b1)
        b.data = sp_q ^ e1;
      if (b.b2)
        b.data = lp_q[b.sts_idx*8 +: 8] ^ e2[b.sts_idx*8 +: 8];
      s = s ^ b.data;
      if (!b.soh)
        l[b.sts_idx*8 +: 8] = l[b.sts_idx*8 +: 8] ^ b.data;
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      // Gaps show inverted data so stale bytes cannot pass
      if ($urandom_range(0, 1) == 1)
      begin
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
      end
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    sp_q = s;
    lp_q = l;
  endtask
endmodule // bpm_framer_model

// ===== verification/bpm_monitor_tb.sv
// Self-checking bench of the receive parity monitor
`timescale 1ns/1ps
module bpm_monitor_tb;
  import bpm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic rx_valid;
  bpm_rx_byte_t rx_byte;
  logic [15:0] awaddr = '0;
  logic [15:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0, irq_n;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] sc, lc, c;
  logic [7:0] e1;
  logic [23:0] e2;
  logic [1:0] m;
  always #25 aclk = ~aclk;
  bpm_framer_model fr (.aclk(aclk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  bpm_monitor dut (.aclk(aclk), .aresetn(aresetn), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_n(irq_n));
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Response ready lags valid to stall the slave once
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && !bready)
        bready <= 1'b1;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && !rready)
        rready <= 1'b1;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  function automatic logic [31:0] inc(input logic fm, input logic [23:0] e);
    logic [31:0] n;
    n = 0;
    for (int k = 0; k < 24; k++)
      n += e[k];
    return fm ? 32'(n != 0) : n;
  endfunction
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(32'hCE4D1183));
    sc = 0;
    lc = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(BPM_ADDR_CTRL, 32'h0, BPM_RESP_OKAY);
    rc(BPM_ADDR_STAT, 32'h0, BPM_RESP_OKAY);
    rc(BPM_ADDR_MASK, 32'h18, BPM_RESP_OKAY);
    rc(BPM_ADDR_SCNT, 32'h0, BPM_RESP_OKAY);
    rc(16'h0010, 32'h0, BPM_RESP_DECERR);
    wr(16'h0010, 32'hFFFF_FFFF, BPM_RESP_DECERR);
    rc(BPM_ADDR_CTRL, 32'h0, BPM_RESP_OKAY);
    fr.send(8'h00, 24'h0);
    fr.send(8'h00, 24'h0);
    // First four frames: every mode with all check bits wrong
    for (int i = 0; i < 14; i++)
    begin
      m = (i < 4) ? 2'(i) : 2'($urandom);
      e1 = (i < 4) ? 8'hFF : ($urandom_range(0, 2) == 0 ? 8'h00 : 8'($urandom));
      e2 = (i < 4) ? 24'hFF_FFFF : ($urandom_range(0, 2) == 0 ? 24'h0 : 24'($urandom));
      c = $urandom;
      c[1:0] = m;
      wr(BPM_ADDR_CTRL, c, BPM_RESP_OKAY);
      rc(BPM_ADDR_CTRL, c & 32'h7F, BPM_RESP_OKAY);
      fr.send(e1, e2);
      sc += inc(m[0], {16'h0, e1});
      lc += inc(m[1], e2);
      chk({31'h0, irq_n}, {31'h0, ({e1, e2} == 32'h0)});
      rc(BPM_ADDR_STAT, {27'h0, e2 != 0, e1 != 0, 3'h0}, BPM_RESP_OKAY);
      wr(BPM_ADDR_SCNT, 32'hFFFF_FFFF, BPM_RESP_OKAY);
      rc(BPM_ADDR_SCNT, sc, BPM_RESP_OKAY);
      rc(BPM_ADDR_LCNT, lc, BPM_RESP_OKAY);
      chk({31'h0, irq_n}, 32'h1);
    end
    wr(BPM_ADDR_MASK, 32'h0, BPM_RESP_OKAY);
    fr.send(8'h01, 24'h0);
    chk({31'h0, irq_n}, 32'h1);
    rc(BPM_ADDR_STAT, 32'h8, BPM_RESP_OKAY);
    wr(BPM_ADDR_MASK, 32'hFFFF_FFFF, BPM_RESP_OKAY);
    rc(BPM_ADDR_MASK, 32'h18, BPM_RESP_OKAY);
    conclude();
  end
endmodule // bpm_monitor_tb
